// ### src/strap_decode.sv
// Decoder from the captured strap registers into configuration controls.
module strap_decode (
    input wire logic [7:0] cap0,
    input wire logic [7:0] cap1,
    input wire logic [7:0] periph,
    output strap_pkg::config_t cfg
);
    // Pure combinational decode of the held register contents.
    always_comb begin
        // PLL range; an upper bit of one is reserved.
        cfg.pll_range = strap_pkg::pll_range_t'(
            cap0[strap_pkg::PLL_RANGE_POS +: 2]); // [R5]
        cfg.pll_range_valid = ~cap0[strap_pkg::PLL_RANGE_POS + 1]; // [R5]
        // Exactly one bus is enabled, none for the reserved code.
        cfg.isa_en = cap0[strap_pkg::BUS_MODE_POS +: 2]
            == strap_pkg::BUS_ISA; // [R6]
        cfg.pcmcia_en = cap0[strap_pkg::BUS_MODE_POS +: 2]
            == strap_pkg::BUS_PCMCIA; // [R6]
        cfg.local_bus_en = cap0[strap_pkg::BUS_MODE_POS +: 2]
            == strap_pkg::BUS_LOCAL; // [R6]
        cfg.clk_sync = cap0[strap_pkg::CLK_SYNC_POS]; // [R7]
        // Upper strap low forces divide by four regardless of lower.
        if (!cap0[strap_pkg::PCI_DIV_POS + 1]) begin
            cfg.pci_div = strap_pkg::DIV_BY_4; // [R8]
        end else if (!cap0[strap_pkg::PCI_DIV_POS]) begin
            cfg.pci_div = strap_pkg::DIV_BY_3; // [R8]
        end else begin
            cfg.pci_div = strap_pkg::DIV_BY_2; // [R8]
        end
        cfg.cpu_mult = cap1[strap_pkg::MULT_POS +: 2]; // [R4]
        cfg.boot_16bit = cap1[strap_pkg::BOOT_WIDTH_POS]; // [R14]
        cfg.serial_two_en = periph[strap_pkg::SER2_POS]; // [R9]
        cfg.serial_one_en = periph[strap_pkg::SER1_POS]; // [R10]
        cfg.kbd_mouse_en = periph[strap_pkg::KBD_POS]; // [R11]
        cfg.parallel_en = periph[strap_pkg::PAR_POS]; // [R12]
    end
endmodule : strap_decode

// ### src/strap_option_latch.sv
// Strap option latch with index/data register access and decoded outputs.
module strap_option_latch (
    input wire logic ref_clk,
    input wire logic nrst,
    // Strap levels on the memory data pins, grouped.
    input strap_pkg::straps_t memory_data_strap_pins,
    // I/O port access: address, write and read strobes, write data.
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Decoded configuration.
    output strap_pkg::config_t cfg
);
    // Captured register contents and the selected index.
    logic [7:0] cap0_reg;
    logic [7:0] cap1_reg;
    logic [7:0] periph_reg;
    logic [7:0] index_reg;
    logic [7:0] rdata_reg;
    // High once straps have been sampled since reset.
    logic captured_reg;
    // Combinational read value for the selected index.
    logic [7:0] sel_data;

    // Capture straps once on the first edge after reset release.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            captured_reg <= 1'b0;
            cap0_reg <= strap_pkg::REG_RESET;
            cap1_reg <= strap_pkg::REG_RESET;
            periph_reg <= strap_pkg::REG_RESET;
        end else if (!captured_reg) begin
            // Single sample; afterwards held until next reset.
            captured_reg <= 1'b1; // [R15]
            cap0_reg <= {memory_data_strap_pins.pci_pll_range_straps,
                         memory_data_strap_pins.bus_mode_straps,
                         1'b0,
                         memory_data_strap_pins.clock_sync_strap,
                         memory_data_strap_pins.pci_div_upper_strap,
                         memory_data_strap_pins.pci_div_lower_strap}; // [R2]
            cap1_reg <= {memory_data_strap_pins.cpu_mult_strap_hi,
                         memory_data_strap_pins.cpu_mult_strap_lo,
                         5'h00,
                         memory_data_strap_pins.boot_width_strap}; // [R4]
            periph_reg <= {memory_data_strap_pins.parallel_enable_strap,
                           memory_data_strap_pins.kbd_mouse_enable_strap,
                           4'h0,
                           memory_data_strap_pins.serial_one_enable_strap,
                           memory_data_strap_pins.serial_two_enable_strap};
        end
    end

    // Index register: software selects which register the data port shows.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            index_reg <= strap_pkg::REG_RESET;
        end else if (io_wr && io_addr == strap_pkg::INDEX_PORT_ADDR) begin
            index_reg <= io_wdata; // [R3]
        end
    end

    // Data port read mux; writes to the data port are ignored.
    always_comb begin
        unique case (index_reg)
            strap_pkg::CAPTURE_0_IDX: sel_data = cap0_reg; // [R3]
            strap_pkg::CAPTURE_1_IDX: sel_data = cap1_reg;
            strap_pkg::PERIPH_IDX: sel_data = periph_reg;
            default: sel_data = strap_pkg::UNMAPPED_DATA;
        endcase
    end

    // Read data registered one cycle after the read strobe.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= strap_pkg::REG_RESET;
        end else if (io_rd && io_addr == strap_pkg::DATA_PORT_ADDR) begin
            rdata_reg <= sel_data;
        end else if (io_rd && io_addr == strap_pkg::INDEX_PORT_ADDR) begin
            rdata_reg <= index_reg;
        end
    end
    assign io_rdata = rdata_reg;

    // Decode held contents into configuration outputs.
    strap_decode u_decode (
        .cap0(cap0_reg),
        .cap1(cap1_reg),
        .periph(periph_reg),
        .cfg(cfg)
    );

    // Captured contents never change once captured. [R1]
    property p_hold;
        @(posedge ref_clk) disable iff (!nrst)
        captured_reg |=> ($stable(cap0_reg) && $stable(cap1_reg)
                          && $stable(periph_reg));
    endproperty
    a_hold: assert property (p_hold) else $error("strap regs changed"); // [R1]

    // Writes to the data port leave the register unchanged. [R1]
    property p_wr_ignored;
        @(posedge ref_clk) disable iff (!nrst)
        (captured_reg && io_wr && io_addr == strap_pkg::DATA_PORT_ADDR)
            |=> $stable(cap0_reg);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) // [R1]
        else $error("write took");

    // First edge after release captures the pins. [R2]
    property p_capture;
        @(posedge ref_clk) disable iff (!nrst)
        !captured_reg |=> (captured_reg
            && cap0_reg[7:6]
               == $past(memory_data_strap_pins.pci_pll_range_straps)
            && cap0_reg[2] == $past(memory_data_strap_pins.clock_sync_strap));
    endproperty
    a_capture: assert property (p_capture) else $error("bad capture"); // [R2]

    // Index 4A read returns the first register next cycle. [R3]
    property p_read0;
        @(posedge ref_clk) disable iff (!nrst)
        (io_rd && io_addr == strap_pkg::DATA_PORT_ADDR
         && index_reg == strap_pkg::CAPTURE_0_IDX)
            |=> io_rdata == $past(cap0_reg);
    endproperty
    a_read0: assert property (p_read0) // [R3]
        else $error("bad read of 4A");

    // Index 4B read returns the second register next cycle. [R4]
    property p_read1;
        @(posedge ref_clk) disable iff (!nrst)
        (io_rd && io_addr == strap_pkg::DATA_PORT_ADDR
         && index_reg == strap_pkg::CAPTURE_1_IDX)
            |=> io_rdata == $past(cap1_reg);
    endproperty
    a_read1: assert property (p_read1) // [R4]
        else $error("bad read of 4B");

    // Index 4C read returns the peripheral enables next cycle. [R9]
    property p_read_periph;
        @(posedge ref_clk) disable iff (!nrst)
        (io_rd && io_addr == strap_pkg::DATA_PORT_ADDR
         && index_reg == strap_pkg::PERIPH_IDX)
            |=> io_rdata == $past(periph_reg);
    endproperty
    a_read_periph: assert property (p_read_periph) // [R9]
        else $error("bad read of 4C");

    // Indices outside the strap set read as zero. [R3]
    property p_unmapped;
        @(posedge ref_clk) disable iff (!nrst)
        (io_rd && io_addr == strap_pkg::DATA_PORT_ADDR
         && index_reg != strap_pkg::CAPTURE_0_IDX
         && index_reg != strap_pkg::CAPTURE_1_IDX
         && index_reg != strap_pkg::PERIPH_IDX)
            |=> io_rdata == strap_pkg::UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) // [R3]
        else $error("unmapped index not zero");

    // An index write is what the next data port access selects. [R3]
    property p_index_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (io_wr && io_addr == strap_pkg::INDEX_PORT_ADDR)
            |=> index_reg == $past(io_wdata);
    endproperty
    a_index_wr: assert property (p_index_wr) // [R3]
        else $error("index lost");

    // Read data stands until the next read strobe. [R3]
    property p_rdata_hold;
        @(posedge ref_clk) disable iff (!nrst)
        !io_rd |=> $stable(io_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // [R3]
        else $error("read data moved");

    // Reserved bits of the second register read zero. [R4]
    property p_rsv1;
        @(posedge ref_clk) disable iff (!nrst)
        captured_reg |-> cap1_reg[5:1] == 5'h00;
    endproperty
    a_rsv1: assert property (p_rsv1) else $error("reserved bits set"); // [R4]

    // At most one bus enabled. [R6]
    property p_one_bus;
        @(posedge ref_clk) disable iff (!nrst)
        $onehot0({cfg.isa_en, cfg.pcmcia_en, cfg.local_bus_en});
    endproperty
    a_one_bus: assert property (p_one_bus) else $error("two buses on"); // [R6]

    // Upper divisor strap low gives divide by four. [R8]
    property p_div4;
        @(posedge ref_clk) disable iff (!nrst)
        !cap0_reg[1] |-> cfg.pci_div == strap_pkg::DIV_BY_4;
    endproperty
    a_div4: assert property (p_div4) else $error("divisor wrong"); // [R8]

    // Parallel and second serial enables and boot width follow their captured straps. [R12]
    property p_periph;
        @(posedge ref_clk) disable iff (!nrst)
        cfg.parallel_en == periph_reg[7] && cfg.serial_two_en == periph_reg[0]
        && cfg.boot_16bit == cap1_reg[0];
    endproperty
    a_periph: assert property (p_periph) else $error("enable wrong"); // [R12]

    // Keyboard and first serial enables follow their straps. [R11]
    property p_kbd_ser1;
        @(posedge ref_clk) disable iff (!nrst)
        cfg.kbd_mouse_en == periph_reg[6]
        && cfg.serial_one_en == periph_reg[1];
    endproperty
    a_kbd_ser1: assert property (p_kbd_ser1) // [R11] [R10]
        else $error("enable off");

    // Upper range strap set marks the PLL range as reserved. [R5]
    property p_pll_valid;
        @(posedge ref_clk) disable iff (!nrst)
        cfg.pll_range_valid != cap0_reg[7]
        && cfg.pll_range == cap0_reg[7:6];
    endproperty
    a_pll_valid: assert property (p_pll_valid) // [R5]
        else $error("PLL range wrong");

    // The reserved bus code enables no bus at all. [R6]
    property p_bus_rsv;
        @(posedge ref_clk) disable iff (!nrst)
        cap0_reg[5:4] == 2'h3
            |-> !(cfg.isa_en || cfg.pcmcia_en || cfg.local_bus_en);
    endproperty
    a_bus_rsv: assert property (p_bus_rsv) else $error("bus on"); // [R6]

    // Clock relation follows its captured strap. [R7]
    property p_clk_sync;
        @(posedge ref_clk) disable iff (!nrst)
        cfg.clk_sync == cap0_reg[2];
    endproperty
    a_clk_sync: assert property (p_clk_sync) else $error("sync wrong"); // [R7]

    // Upper divisor strap high and lower low gives divide by three. [R8]
    property p_div3;
        @(posedge ref_clk) disable iff (!nrst)
        cap0_reg[1:0] == 2'h2 |-> cfg.pci_div == strap_pkg::DIV_BY_3;
    endproperty
    a_div3: assert property (p_div3) else $error("not div 3"); // [R8]

    // Both divisor straps high gives divide by two. [R8]
    property p_div2;
        @(posedge ref_clk) disable iff (!nrst)
        cap0_reg[1:0] == 2'h3 |-> cfg.pci_div == strap_pkg::DIV_BY_2;
    endproperty
    a_div2: assert property (p_div2) else $error("not div 2"); // [R8]

    // Main scenarios.
    c_isa: cover property (@(posedge ref_clk) captured_reg && cfg.isa_en);
    c_local: cover property (@(posedge ref_clk)
        captured_reg && cfg.local_bus_en);
    c_rsv_bus: cover property (@(posedge ref_clk)
        captured_reg && cap0_reg[5:4] == 2'h3);
    c_read1: cover property (@(posedge ref_clk)
        io_rd && io_addr == strap_pkg::DATA_PORT_ADDR
        && index_reg == strap_pkg::CAPTURE_1_IDX);
endmodule : strap_option_latch

// ### src/strap_pkg.sv
// Package with register offsets, field positions and types of the strap latch.
// Summary of operation
// [R1] Strap capture registers are read only.
// [R2] Registers load from strap pins after reset.
// [R3] First register at index 4A via port.
// [R4] Second register: multiplier bits 7-6, width bit0.
// [R5] First bits 7-6 give PCI PLL range.
// [R6] First bits 5-4 select one bus mode.
// [R7] First bit 2 sets memory/host clock sync.
// [R8] First bits 1-0 set PCI clock divisor.
// [R9] Index 4C bit 0 enables second serial.
// [R10] Index 4C bit 1 enables first serial.
// [R11] Index 4C bit 6 enables keyboard/mouse.
// [R12] Index 4C bit 7 enables parallel port.
// [R13] Board pulls up terminal count, DMA encoding.
// [R14] Second bit 0 sets boot device width.
// [R15] Sample once at reset release, then hold.
package strap_pkg;
    // Index port and data port I/O addresses.
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h0022;
    localparam logic [15:0] DATA_PORT_ADDR = 16'h0023;
    // Register indices.
    localparam logic [7:0] CAPTURE_0_IDX = 8'h4A;
    localparam logic [7:0] CAPTURE_1_IDX = 8'h4B;
    localparam logic [7:0] PERIPH_IDX = 8'h4C;
    // Field positions in the first register.
    localparam int PLL_RANGE_POS = 6;
    localparam int BUS_MODE_POS = 4;
    localparam int CLK_SYNC_POS = 2;
    localparam int PCI_DIV_POS = 0;
    // Field positions in the second register.
    localparam int MULT_POS = 6;
    localparam int BOOT_WIDTH_POS = 0;
    // Field positions in the peripheral enable register.
    localparam int SER2_POS = 0;
    localparam int SER1_POS = 1;
    localparam int KBD_POS = 6;
    localparam int PAR_POS = 7;
    // Value read for unmapped indices and reserved bits.
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;

    // PCI PLL range encoding.
    typedef enum logic [1:0] {
        PLL_16_32 = 2'h0,
        PLL_32_64 = 2'h1,
        PLL_RSV_A = 2'h2,
        PLL_RSV_B = 2'h3
    } pll_range_t;

    // Expansion bus mode encoding.
    typedef enum logic [1:0] {
        BUS_ISA = 2'h0,
        BUS_PCMCIA = 2'h1,
        BUS_LOCAL = 2'h2,
        BUS_RSV = 2'h3
    } bus_mode_t;

    // PCI clock divisor encoding.
    typedef enum logic [1:0] {
        DIV_BY_4 = 2'h0,
        DIV_BY_3 = 2'h1,
        DIV_BY_2 = 2'h2
    } pci_div_t;

    // Raw strap pin levels grouped together.
    typedef struct packed {
        logic [1:0] pci_pll_range_straps;
        logic [1:0] bus_mode_straps;
        logic clock_sync_strap;
        logic pci_div_upper_strap;
        logic pci_div_lower_strap;
        logic cpu_mult_strap_hi;
        logic cpu_mult_strap_lo;
        logic boot_width_strap;
        logic serial_two_enable_strap;
        logic serial_one_enable_strap;
        logic kbd_mouse_enable_strap;
        logic parallel_enable_strap;
    } straps_t;

    // Decoded configuration driven to the rest of the chip.
    typedef struct packed {
        pll_range_t pll_range;
        logic pll_range_valid;
        logic isa_en;
        logic pcmcia_en;
        logic local_bus_en;
        logic clk_sync;
        pci_div_t pci_div;
        logic [1:0] cpu_mult;
        logic boot_16bit;
        logic serial_two_en;
        logic serial_one_en;
        logic kbd_mouse_en;
        logic parallel_en;
    } config_t;
endpackage : strap_pkg

// ### tb/board_straps.sv
// Board strap resistor model seen on the shared memory data pins.
module board_straps (
    input wire logic ref_clk,
    input wire logic traffic,
    input strap_pkg::straps_t pattern,
    output strap_pkg::straps_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // Terminal count and DMA encoding pins are always pulled high.
    localparam logic [3:0] TC_DACK_PULLS = 4'hF;
    // Flips every clock so that bus traffic never holds the strap levels.
    logic flip_reg = 1'b0;
    // Toggle source for the traffic pattern.
    always @(posedge ref_clk) begin
        flip_reg <= ~flip_reg;
    end
    // Resistor levels while quiet, changing memory data once traffic runs.
    assign pins = traffic
        ? (pattern ^ {$bits(strap_pkg::straps_t){flip_reg}}) : pattern;
endmodule : board_straps

// ### tb/strap_option_latch_bench.sv
// Self-checking bench for the strap option latch.
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("ERROR %s expected %h seen %h", what, exp, got); \
        end \
    end
module strap_option_latch_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic traffic = 1'b0;
    strap_pkg::straps_t pattern = '0;
    strap_pkg::straps_t pins;
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    strap_pkg::config_t cfg;
    logic [7:0] rd_val;
    int miscompares = 0;
    int samples_checked = 0;
    // Strap patterns that together cover every field code.
    strap_pkg::straps_t pats [4] = '{14'h00AA, 14'h1755, 14'h29FF, 14'h3E00};

    // Clock at 40 ns period.
    always #20 ref_clk = ~ref_clk;

    board_straps board_u (.ref_clk(ref_clk), .traffic(traffic),
        .pattern(pattern), .pins(pins));

    strap_option_latch dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .memory_data_strap_pins(pins), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .cfg(cfg));

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // One port access with a one-cycle strobe; read data lands in rd_val.
    task automatic io_cycle(input logic wr, input logic [15:0] addr,
        input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        io_wr = wr;
        io_rd = ~wr;
        io_addr = addr;
        io_wdata = data;
        @(posedge ref_clk);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        @(posedge ref_clk);
        #1;
        rd_val = io_rdata;
    endtask : io_cycle

    // Selects an index, reads the data port and compares.
    task automatic read_reg(input logic [7:0] idx, input logic [7:0] exp,
        input string what);
        io_cycle(1'b1, strap_pkg::INDEX_PORT_ADDR, idx);
        io_cycle(1'b0, strap_pkg::DATA_PORT_ADDR, 8'h00);
        `CHK(what, exp, rd_val)
    endtask : read_reg

    // Resets with a new strap pattern; traffic starts after capture.
    task automatic do_reset(input strap_pkg::straps_t s);
        @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        traffic = 1'b0;
        pattern = s;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("rdata in reset", 8'h00, io_rdata)
        nrst = 1'b1;
        @(posedge ref_clk);
        #1;
        traffic = 1'b1;
    endtask : do_reset

    // Reads all three registers and compares the decoded configuration.
    task automatic check_all(input strap_pkg::straps_t s);
        strap_pkg::config_t e;
        e.pll_range = strap_pkg::pll_range_t'(s.pci_pll_range_straps);
        e.pll_range_valid = ~s.pci_pll_range_straps[1];
        e.isa_en = (s.bus_mode_straps == 2'h0);
        e.pcmcia_en = (s.bus_mode_straps == 2'h1);
        e.local_bus_en = (s.bus_mode_straps == 2'h2);
        e.clk_sync = s.clock_sync_strap;
        e.pci_div = !s.pci_div_upper_strap ? strap_pkg::DIV_BY_4 :
            s.pci_div_lower_strap ? strap_pkg::DIV_BY_2 : strap_pkg::DIV_BY_3;
        e.cpu_mult = {s.cpu_mult_strap_hi, s.cpu_mult_strap_lo};
        e.boot_16bit = s.boot_width_strap;
        e.serial_two_en = s.serial_two_enable_strap;
        e.serial_one_en = s.serial_one_enable_strap;
        e.kbd_mouse_en = s.kbd_mouse_enable_strap;
        e.parallel_en = s.parallel_enable_strap;
        read_reg(strap_pkg::CAPTURE_0_IDX, {s.pci_pll_range_straps,
            s.bus_mode_straps, 1'b0, s.clock_sync_strap,
            s.pci_div_upper_strap, s.pci_div_lower_strap}, "cap0");
        read_reg(strap_pkg::CAPTURE_1_IDX, {s.cpu_mult_strap_hi,
            s.cpu_mult_strap_lo, 5'h00, s.boot_width_strap}, "cap1");
        read_reg(strap_pkg::PERIPH_IDX, {s.parallel_enable_strap,
            s.kbd_mouse_enable_strap, 4'h0, s.serial_one_enable_strap,
            s.serial_two_enable_strap}, "periph");
        `CHK("config", e, cfg)
    endtask : check_all

    // Captures one pattern and checks registers and decode.
    task automatic capture_and_decode(input strap_pkg::straps_t s);
        do_reset(s);
        check_all(s);
    endtask : capture_and_decode

    // Writes to the data port, probes an unmapped index, then rechecks.
    task automatic read_only_and_hold(input strap_pkg::straps_t s);
        io_cycle(1'b1, strap_pkg::INDEX_PORT_ADDR, strap_pkg::CAPTURE_0_IDX);
        io_cycle(1'b1, strap_pkg::DATA_PORT_ADDR, 8'hFF);
        io_cycle(1'b1, strap_pkg::INDEX_PORT_ADDR, strap_pkg::CAPTURE_1_IDX);
        io_cycle(1'b1, strap_pkg::DATA_PORT_ADDR, 8'hFF);
        read_reg(8'h5F, strap_pkg::UNMAPPED_DATA, "unmapped");
        io_cycle(1'b0, strap_pkg::INDEX_PORT_ADDR, 8'h00);
        `CHK("index readback", 8'h5F, rd_val)
        repeat (20) @(posedge ref_clk);
        check_all(s);
    endtask : read_only_and_hold

    // Main sequence.
    initial begin
        for (int i = 0; i < 4; i++) begin
            capture_and_decode(pats[i]);
            read_only_and_hold(pats[i]);
        end
        tally_and_finish();
    end

    // Watchdog that cuts a hang short.
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : strap_option_latch_bench
